// ### fsr_cmd.sv
// Serial flash status, upper address byte and array read command front end
`timescale 1ns/1ps
`include "fsr_map.svh"

// ==========================================================================
// Read data FIFO
module fsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       flush_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]      count_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int NW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // Honest flags from the occupancy count
  assign in_ready_o  = (count_o != NW'(DEPTH));
  assign out_valid_o = (count_o != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o && !flush_i;
  assign pop         = out_valid_o && out_ready_i && !flush_i;

  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (srst_i || flush_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count_o <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count_o <= count_o + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule : fsr_fifo

// ==========================================================================
// Command front end
module fsr_cmd import fsr_pkg::*; #(
  parameter int          FIFO_DEPTH = 8,
  parameter logic [15:0] TW_CYCLES  = 16'(`FSR_TW_CYC)
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        HW_RESET_I,
  // Serial link pins
  input  wire logic        CS_N_I,
  input  wire logic        SCLK_I,
  input  wire logic [3:0]  IO_I,
  output logic      [3:0]  IO_O,
  output logic      [3:0]  IO_OE_O,
  // Mode
  input  wire logic        FOUR_WIRE_MODE_I,
  // Array read port
  output logic             MEM_REQ_O,
  output logic      [31:0] MEM_ADDR_O,
  input  wire logic        MEM_RVALID_I,
  input  wire logic [7:0]  MEM_RDATA_I,
  output logic             MEM_RREADY_O,
  // State
  output fsr_status_s      STATUS_O,
  output logic      [7:0]  EXT_ADDR_O,
  output logic             ADDR_MODE_O,
  output logic             BUSY_O,
  output logic             WEL_O
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // Masked write with bits that may only rise
  function automatic logic [7:0] fsr_merge(input logic [7:0] old, input logic [7:0] data,
                                           input logic [7:0] mask, input logic [7:0] sticky);
    fsr_merge = (old & ~mask) | (data & mask) | (old & sticky);
  endfunction : fsr_merge

  fsr_state_e  state;
  fsr_src_e    src;
  fsr_status_s sr;
  fsr_status_s nv;
  fsr_status_s pend;
  logic [2:0]  pend_en;
  logic        sclk_q, cs_q, busy, write_enable_latch, vwe, addr_mode_state, rd_active, oe;
  logic [1:0]  param;
  logic [7:0]  ext, opcode, shreg, d0, d1, os;
  logic [3:0]  bcnt, byte_cnt, acnt, dcnt, obc, oreg;
  logic [23:0] abuf;
  logic [15:0] timer;
  logic        op_valid;
  logic [CW-1:0] credits;

  // ========================================================================
  // Link edges and byte assembly
  logic       rise, fall, cs_rise, quad, counting, byte_done;
  logic [3:0] step, nab, dummy;
  logic [7:0] in_byte;
  assign quad      = FOUR_WIRE_MODE_I;
  assign rise      = SCLK_I && !sclk_q && !CS_N_I;
  assign fall      = !SCLK_I && sclk_q && !CS_N_I;
  assign cs_rise   = CS_N_I && !cs_q;
  assign step      = quad ? 4'h4 : 4'h1;
  assign in_byte   = quad ? {shreg[3:0], IO_I} : {shreg[6:0], IO_I[0]};
  assign counting  = (state == FSR_ST_CMD) || (state == FSR_ST_ADDR) || (state == FSR_ST_DIN);
  assign byte_done = rise && counting && ((bcnt + step) == 4'h8);

  // Opcode classes, decided on the completed first byte
  logic is_srd, is_din, is_read, is_fast, rd_ok;
  assign is_srd  = (in_byte == `FSR_OP_RDSR1) || (in_byte == `FSR_OP_RDSR2)
                || (in_byte == `FSR_OP_RDSR3);
  assign is_din  = (in_byte == `FSR_OP_WRSR1) || (in_byte == `FSR_OP_WRSR2)
                || (in_byte == `FSR_OP_WRSR3) || (in_byte == `FSR_OP_WREXT)
                || (in_byte == `FSR_OP_SETPARAM) || (in_byte == `FSR_OP_WREN)
                || (in_byte == `FSR_OP_WRDI) || (in_byte == `FSR_OP_VWREN)
                || (in_byte == `FSR_OP_EN32) || (in_byte == `FSR_OP_EX32);
  assign is_read = ((in_byte == `FSR_OP_READ) || (in_byte == `FSR_OP_READ32)) && !quad;
  assign is_fast = (in_byte == `FSR_OP_FREAD);
  assign rd_ok   = is_read || is_fast;

  // Address length and dummy clocks
  assign nab   = (addr_mode_state || opcode == `FSR_OP_READ32) ? 4'h4 : 4'h3;
  assign dummy = quad ? {1'b0, param, 1'b0} + 4'h2 : `FSR_SPI_DUMMY;

  // Address completion
  logic        addr_done;
  logic [31:0] full_addr;
  assign addr_done = byte_done && (state == FSR_ST_ADDR) && (acnt == nab - 4'h1);
  assign full_addr = (nab == 4'h4) ? {abuf, in_byte}
                                   : {ext, abuf[15:0], in_byte};

  // ========================================================================
  // Command completion at chip select rise
  logic done_ok, st_op, st_cnt_ok, st_nv, st_vol;
  logic [2:0] st_en;
  fsr_status_s st_new;
  logic [7:0] sticky2, mask2;
  assign done_ok   = cs_rise && op_valid && (bcnt == 4'h0);
  assign st_op     = (opcode == `FSR_OP_WRSR1) || (opcode == `FSR_OP_WRSR2)
                  || (opcode == `FSR_OP_WRSR3);
  assign st_cnt_ok = (byte_cnt == 4'h1) || (opcode == `FSR_OP_WRSR1 && byte_cnt == 4'h2);
  assign st_nv     = done_ok && st_op && st_cnt_ok && write_enable_latch;
  assign st_vol    = done_ok && st_op && st_cnt_ok && !write_enable_latch && vwe;
  assign st_en     = (opcode == `FSR_OP_WRSR1) ? {1'b0, byte_cnt == 4'h2, 1'b1}
                   : (opcode == `FSR_OP_WRSR2) ? 3'b010 : 3'b100;
  // Quad enable is held in four-wire mode since that mode depends on it
  assign mask2     = quad ? (`FSR_SR2_WR_MASK & ~`FSR_SR2_QE_MASK) : `FSR_SR2_WR_MASK;
  assign sticky2   = `FSR_SR2_LB_MASK | (write_enable_latch ? 8'h00 : `FSR_SR2_SRL_MASK);
  assign st_new.sr1 = fsr_merge(sr.sr1, d0, `FSR_SR1_WR_MASK, 8'h00);
  assign st_new.sr2 = fsr_merge(sr.sr2, (opcode == `FSR_OP_WRSR1) ? d1 : d0, mask2, sticky2);
  assign st_new.sr3 = fsr_merge(sr.sr3, d0, `FSR_SR3_WR_MASK, 8'h00);

  logic single_ok, nv_done;
  assign single_ok = done_ok && (byte_cnt == 4'h0);
  assign nv_done   = busy && (timer == 16'h1);

  // ========================================================================
  // Pin history
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= SCLK_I;
      cs_q   <= CS_N_I;
    end
  end

  // Status registers: stored copies survive the pin reset, volatile ones do not
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sr <= {3{`FSR_SR_RESET}};
      nv <= {3{`FSR_SR_RESET}};
    end else if (HW_RESET_I) begin
      sr <= nv;
    end else if (nv_done) begin
      if (pend_en[0]) begin sr.sr1 <= pend.sr1; nv.sr1 <= pend.sr1; end
      if (pend_en[1]) begin sr.sr2 <= pend.sr2; nv.sr2 <= pend.sr2; end
      if (pend_en[2]) begin sr.sr3 <= pend.sr3; nv.sr3 <= pend.sr3; end
    end else if (st_vol) begin
      if (st_en[0]) sr.sr1 <= st_new.sr1;
      if (st_en[1]) sr.sr2 <= st_new.sr2;
      if (st_en[2]) sr.sr3 <= st_new.sr3;
    end
  end

  // Self-timed stored write cycle
  always_ff @(posedge CLK_I) begin
    if (SRST_I || HW_RESET_I) begin
      busy    <= 1'b0;
      timer   <= 16'h0;
      pend    <= '0;
      pend_en <= 3'b000;
    end else if (st_nv) begin
      busy    <= 1'b1;
      timer   <= TW_CYCLES;
      pend    <= st_new;
      pend_en <= st_en;
    end else if (busy) begin
      timer <= timer - 16'h1;
      busy  <= !nv_done;
    end
  end

  // Write enable latches
  always_ff @(posedge CLK_I) begin
    if (SRST_I || HW_RESET_I) begin
      write_enable_latch <= 1'b0;
      vwe <= 1'b0;
    end else begin
      if (nv_done) write_enable_latch <= 1'b0;
      else if (single_ok && opcode == `FSR_OP_WREN) write_enable_latch <= 1'b1;
      else if (single_ok && opcode == `FSR_OP_WRDI) write_enable_latch <= 1'b0;
      if (single_ok && opcode == `FSR_OP_VWREN) vwe <= 1'b1;
      else if (st_vol) vwe <= 1'b0;
    end
  end

  // Address mode, upper address byte and read parameters
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      addr_mode_state   <= 1'b0;
      ext   <= `FSR_EXT_RESET;
      param <= `FSR_PARAM_RESET;
    end else if (HW_RESET_I) begin
      addr_mode_state   <= nv.sr3[`FSR_SR3_ADP_BIT];
      ext   <= `FSR_EXT_RESET;
      param <= `FSR_PARAM_RESET;
    end else begin
      if (single_ok && opcode == `FSR_OP_EN32) addr_mode_state <= 1'b1;
      else if (single_ok && opcode == `FSR_OP_EX32) addr_mode_state <= 1'b0;
      if (addr_done && addr_mode_state) ext <= abuf[23:16];
      else if (done_ok && opcode == `FSR_OP_WREXT && byte_cnt == 4'h1 && write_enable_latch) ext <= d0;
      if (done_ok && opcode == `FSR_OP_SETPARAM && byte_cnt == 4'h1) begin
        param <= d0[`FSR_PARAM_MSB:`FSR_PARAM_LSB];
      end
    end
  end

  // ========================================================================
  // Command engine on serial clock edges
  logic [7:0] sr_live, load_byte;
  logic       fifo_valid, fifo_in_ready, pop;
  logic [7:0] fifo_data;
  assign sr_live   = (opcode == `FSR_OP_RDSR2) ? sr.sr2
                   : (opcode == `FSR_OP_RDSR3) ? {sr.sr3[7:1], addr_mode_state}
                   : {sr.sr1[7:2], write_enable_latch, busy};
  assign load_byte = (src == FSR_SRC_STATUS) ? sr_live
                   : (src == FSR_SRC_EXT) ? ext
                   : (fifo_valid ? fifo_data : `FSR_IDLE_BYTE);
  assign pop       = fall && (state == FSR_ST_OUT) && (obc == 4'h0) && (src == FSR_SRC_MEM);

  always_ff @(posedge CLK_I) begin
    if (SRST_I || HW_RESET_I || CS_N_I) begin
      state    <= FSR_ST_CMD;
      src      <= FSR_SRC_STATUS;
      op_valid <= 1'b0;
      bcnt     <= 4'h0;
      byte_cnt <= 4'h0;
      acnt     <= 4'h0;
      dcnt     <= 4'h0;
      obc      <= 4'h0;
      oreg     <= 4'h0;
      oe       <= 1'b0;
      if (SRST_I) begin
        opcode <= 8'h00;
        shreg  <= 8'h00;
        abuf   <= 24'h0;
        os     <= 8'h00;
        d0     <= 8'h00;
        d1     <= 8'h00;
      end
    end else begin
      if (rise && counting) begin
        shreg <= in_byte;
        bcnt  <= byte_done ? 4'h0 : bcnt + step;
      end
      case (state)
        FSR_ST_CMD: begin
          if (byte_done) begin
            opcode <= in_byte;
            if (is_srd) begin
              state <= FSR_ST_OUT;
              src   <= FSR_SRC_STATUS;
            end else if (busy) begin
              state <= FSR_ST_IGNORE;
            end else if (in_byte == `FSR_OP_RDEXT) begin
              state <= FSR_ST_OUT;
              src   <= FSR_SRC_EXT;
            end else if (rd_ok) begin
              state <= FSR_ST_ADDR;
              src   <= FSR_SRC_MEM;
            end else if (is_din) begin
              state    <= FSR_ST_DIN;
              op_valid <= 1'b1;
            end else begin
              state <= FSR_ST_IGNORE;
            end
          end
        end
        FSR_ST_ADDR: begin
          if (byte_done) begin
            abuf <= {abuf[15:0], in_byte};
            acnt <= acnt + 4'h1;
            if (addr_done) begin
              dcnt  <= dummy;
              state <= (opcode == `FSR_OP_FREAD) ? FSR_ST_DUMMY : FSR_ST_OUT;
            end
          end
        end
        FSR_ST_DUMMY: begin
          if (rise) begin
            dcnt <= dcnt - 4'h1;
            if (dcnt == 4'h1) state <= FSR_ST_OUT;
          end
        end
        FSR_ST_DIN: begin
          if (byte_done) begin
            if (byte_cnt == 4'h0) d0 <= in_byte;
            if (byte_cnt == 4'h1) d1 <= in_byte;
            if (byte_cnt != 4'hF) byte_cnt <= byte_cnt + 4'h1;
          end
        end
        FSR_ST_OUT: begin
          // Each falling edge puts the next bit or nibble out, MSB first
          if (fall) begin
            oe  <= 1'b1;
            obc <= (obc + step == 4'h8) ? 4'h0 : obc + step;
            if (obc == 4'h0) begin
              oreg <= quad ? load_byte[7:4] : {load_byte[7], 3'b000};
              os   <= quad ? {load_byte[3:0], 4'h0} : {load_byte[6:0], 1'b0};
            end else begin
              oreg <= quad ? os[7:4] : {os[7], 3'b000};
              os   <= quad ? {os[3:0], 4'h0} : {os[6:0], 1'b0};
            end
          end
        end
        default: begin
          state <= FSR_ST_IGNORE;
        end
      endcase
    end
  end

  // ========================================================================
  // Array prefetch: credits count requests in flight plus bytes held
  logic [CW-1:0] fifo_count;
  logic          drop, flush, taken;
  assign flush        = cs_rise || HW_RESET_I;
  // No request in the flush cycle: its byte would come back after the frame and only be dropped
  assign MEM_REQ_O    = rd_active && !flush && (credits < CW'(FIFO_DEPTH));
  assign drop         = MEM_RVALID_I && !rd_active;
  // A byte handed over in the flush cycle is thrown away, so it leaves the credits too
  assign taken        = MEM_RVALID_I && fifo_in_ready && rd_active;
  // Stale bytes after chip select rise are taken and thrown away
  assign MEM_RREADY_O = rd_active ? fifo_in_ready : 1'b1;

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rd_active  <= 1'b0;
      MEM_ADDR_O <= 32'h0;
      credits    <= '0;
    end else begin
      if (flush) rd_active <= 1'b0;
      else if (addr_done) rd_active <= 1'b1;
      if (addr_done) MEM_ADDR_O <= full_addr;
      else if (MEM_REQ_O) MEM_ADDR_O <= MEM_ADDR_O + 32'h1;
      credits <= (flush ? credits - fifo_count - CW'(taken) : credits - CW'(pop && fifo_valid))
               + CW'(MEM_REQ_O) - CW'(drop);
    end
  end

  fsr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .srst_i      (SRST_I),
    .flush_i     (flush),
    .in_valid_i  (MEM_RVALID_I && rd_active),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (MEM_RDATA_I),
    .out_valid_o (fifo_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_data),
    .count_o     (fifo_count)
  );

  // ========================================================================
  // Outputs
  assign IO_O        = quad ? oreg : {2'b00, oreg[3], 1'b0};
  assign IO_OE_O     = oe ? (quad ? 4'hF : 4'h2) : 4'h0;
  assign STATUS_O    = {sr.sr3[7:1], addr_mode_state, sr.sr2, sr.sr1[7:2], write_enable_latch, busy};
  assign EXT_ADDR_O  = ext;
  assign ADDR_MODE_O = addr_mode_state;
  assign BUSY_O      = busy;
  assign WEL_O       = write_enable_latch;
endmodule : fsr_cmd

// ### fsr_cmd_bench.sv
// Self-checking bench for the flash command front end
`timescale 1ns/1ps
module fsr_cmd_bench import fsr_pkg::*;;
  logic        clk = 1'b0, srst = 1'b1, hwr = 1'b0, mode = 1'b0, rvalid = 1'b0;
  logic        rready, req, busy, write_enable_latch, amode, cs_n, sclk, hdone;
  logic [7:0]  rdata = 8'h00, ext, ea;
  logic [31:0] maddr, rnd = 32'h3EA71AB5, mq[$];
  logic [3:0]  hio, dio, doe, pin;
  logic [63:0] hdat, exp_q[$];
  int          err_count = 0, cmp_count = 0, nreq = 0;
  fsr_status_s status;
  // Wire level: whoever enables a lane drives it
  assign pin = (doe & dio) | (~doe & hio);
  always #2 clk = ~clk;

  fsr_cmd #(.FIFO_DEPTH(8), .TW_CYCLES(16'd200)) u_dut (.CLK_I(clk), .SRST_I(srst),
    .HW_RESET_I(hwr), .CS_N_I(cs_n), .SCLK_I(sclk), .IO_I(pin), .IO_O(dio), .IO_OE_O(doe),
    .FOUR_WIRE_MODE_I(mode), .MEM_REQ_O(req), .MEM_ADDR_O(maddr), .MEM_RVALID_I(rvalid),
    .MEM_RDATA_I(rdata), .MEM_RREADY_O(rready), .STATUS_O(status), .EXT_ADDR_O(ea),
    .ADDR_MODE_O(amode), .BUSY_O(busy), .WEL_O(write_enable_latch));
  fsr_host u_host (.clk_i(clk), .io_i(pin), .cs_n_o(cs_n), .sclk_o(sclk), .io_o(hio),
    .done_o(hdone), .rdata_o(hdat));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] fd(input logic [31:0] a);
    return a[7:0] ^ a[31:24] ^ 8'h3C;
  endfunction : fd
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic test_done;
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task automatic op(input logic [7:0] c, input int ln = 1);
    u_host.frame(ln, 8 / ln, {c, 56'h0}, 0);
  endtask : op
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input int nb, input int ln = 1);
    u_host.frame(ln, (8 + nb) / ln, {c, v, 40'h0}, 0);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [39:0] a, input int na, input int nd,
                    input logic [63:0] e);
    exp_q.push_back(e);
    u_host.frame(1, 8 + na, {c, a, 16'h0}, nd);
  endtask : rd
  task automatic rs(input logic [7:0] c, input logic [7:0] e);
    rd(c, 40'h0, 0, 8, {56'h0, e});
  endtask : rs
  // Bounded wait for the timed write cycle
  task automatic idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask : idle
  task automatic hr;
    hwr <= 1'b1;
    @(posedge clk);
    hwr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : hr

  // ========================================================================
  // Array model: in order, random stalls so the read buffer fills and refuses
  always @(posedge clk) begin
    if (req) begin
      mq.push_back(maddr);
      nreq <= nreq + 1;
    end
    if (!rvalid || rready) begin
      rnd = xs(rnd);
      // A lone request is answered at once: the first byte has only three clocks to land
      rvalid <= mq.size() > 0 && (rnd[0] || mq.size() == 1);
      if (mq.size() > 0 && (rnd[0] || mq.size() == 1)) rdata <= fd(mq.pop_front());
    end
  end
  // Scoreboard: each finished read frame takes the oldest note
  always @(posedge clk) begin
    if (hdone) chk("link_read", exp_q.size() ? exp_q.pop_front() : 64'hX, hdat);
  end

  initial begin
    logic [31:0] a;
    logic [7:0]  b;
    int n;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rs(8'h05, 8'h00);
    rs(8'h35, 8'h00);
    rs(8'h15, 8'h00);
    rs(8'hC8, 8'h00);
    wr(8'h01, 16'hFF00, 8);
    rs(8'h05, 8'h00);
    op(8'h06);
    rs(8'h05, 8'h02);
    op(8'h04);
    rs(8'h05, 8'h00);
    op(8'h06);
    wr(8'h01, 16'hFF00, 8);
    rs(8'h05, 8'h03);
    idle();
    rs(8'h05, 8'hFC);
    // Two-byte legacy form, then lock bits survive a clearing write
    op(8'h06);
    wr(8'h01, 16'h00FF, 16);
    idle();
    rs(8'h35, 8'h7B);
    op(8'h06);
    wr(8'h31, 16'h0000, 8);
    idle();
    rs(8'h35, 8'h38);
    op(8'h06);
    wr(8'h01, 16'hA400, 8);
    idle();
    rs(8'h05, 8'hA4);
    rs(8'h35, 8'h38);
    // Volatile path, then reset restores stored values
    op(8'h50);
    wr(8'h11, 16'hFF00, 8);
    chk("busy_vol", 64'h0, {63'h0, busy});
    rs(8'h15, 8'hE6);
    rs(8'h05, 8'hA4);
    op(8'h50);
    wr(8'h31, 16'h0300, 8);
    op(8'h50);
    wr(8'h31, 16'h0000, 8);
    rs(8'h35, 8'h39);
    hr();
    rs(8'h15, 8'h00);
    rs(8'h35, 8'h38);
    // Four-wire mode: quad enable frozen, basic read refused
    mode <= 1'b1;
    op(8'h50, 4);
    wr(8'h31, 16'hFF00, 8, 4);
    @(posedge clk);
    chk("sr2_four_wire", 64'h79, {56'h0, status.sr2});
    n = nreq;
    u_host.frame(4, 8, {8'h03, 24'h000100, 32'h0}, 0);
    chk("reqs_four_wire", 64'(n), 64'(nreq));
    mode <= 1'b0;
    hr();
    // Upper address byte
    rnd = xs(rnd);
    ext = rnd[7:0];
    op(8'h06);
    wr(8'hC5, {ext, 8'h00}, 8);
    rs(8'hC8, ext);
    op(8'h04);
    wr(8'hC5, {~ext, 8'h00}, 8);
    rs(8'hC8, ext);
    // Array reads in both address modes
    a = {ext, rnd[31:8]};
    rd(8'h03, {a[23:0], 16'h0}, 24, 16, {48'h0, fd(a), fd(a + 1)});
    rd(8'h0B, {a[23:0], 16'h0}, 32, 8, {56'h0, fd(a)});
    a = xs(a);
    rd(8'h13, {a, 8'h0}, 32, 8, {56'h0, fd(a)});
    op(8'hB7);
    rs(8'h15, 8'h01);
    a = xs(a);
    rd(8'h03, {a, 8'h0}, 32, 8, {56'h0, fd(a)});
    rs(8'hC8, a[31:24]);
    op(8'hE9);
    rs(8'h15, 8'h00);
    // Four-wire fast read: default two dummy clocks, lane 1 carries bits 5 and 1
    b = fd(a);
    mode <= 1'b1;
    exp_q.push_back({62'h0, b[5], b[1]});
    u_host.frame(4, 10, {8'h0B, a[23:0], 32'h0}, 2);
    mode <= 1'b0;
    // Read during the timed cycle is dropped
    op(8'h06);
    wr(8'h01, 16'h0000, 8);
    n = nreq;
    u_host.frame(1, 32, {8'h03, a[23:0], 32'h0}, 0);
    chk("reqs_busy", 64'(n), 64'(nreq));
    idle();
    test_done();
  end
endmodule : fsr_cmd_bench

// ### fsr_cmd_chk.sv
// Concurrent checks on the ports of the flash command front end
`timescale 1ns/1ps
module fsr_cmd_chk import fsr_pkg::*; (
  // Clock and resets
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        HW_RESET_I,
  // Link and read port
  input wire logic        CS_N_I,
  input wire logic [3:0]  IO_OE_O,
  input wire logic        MEM_REQ_O,
  // State
  input wire fsr_status_s STATUS_O,
  input wire logic [7:0]  EXT_ADDR_O,
  input wire logic        ADDR_MODE_O,
  input wire logic        BUSY_O,
  input wire logic        WEL_O
);
  // ========================================================================
  // Both resets rewrite state at will, so checks pause across them
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I || HW_RESET_I);

  busy_hold_a: assert property ($rose(BUSY_O) |-> BUSY_O [*8])
    else $error("busy cycle shorter than eight clocks");
  busy_start_a: assert property ($rose(BUSY_O) |-> CS_N_I)
    else $error("busy began while chip select low");
  busy_wel_a: assert property ($fell(BUSY_O) |-> !WEL_O && !STATUS_O.sr1[0])
    else $error("latch still set after write cycle");
  flags_mirror_a: assert property (STATUS_O.sr1[1:0] == {WEL_O, BUSY_O})
    else $error("status flags differ from level outputs");
  mode_mirror_a: assert property (ADDR_MODE_O == STATUS_O.sr3[0])
    else $error("address mode differs from status bit");
  ro_bits_a: assert property ({STATUS_O.sr2[7], STATUS_O.sr2[2], STATUS_O.sr3[4:3]} == 4'h0)
    else $error("read-only status bit changed");
  lock_keep_a: assert property (|($past(STATUS_O.sr2[5:3]) & ~STATUS_O.sr2[5:3])
    |-> $past(HW_RESET_I) || $past(SRST_I)) else $error("lock bit returned to zero");
  ext_clear_a: assert property ($past(HW_RESET_I) |-> EXT_ADDR_O == 8'h00 && !WEL_O)
    else $error("upper byte kept over reset");
  req_gate_a: assert property ($rose(MEM_REQ_O) |-> !CS_N_I && !BUSY_O)
    else $error("array request outside a read frame");
  oe_release_a: assert property ($rose(CS_N_I) |-> ##2 IO_OE_O == 4'h0)
    else $error("lanes still driven after frame end");

  // Main scenarios reached
  cover property ($rose(BUSY_O));
  cover property ($rose(MEM_REQ_O));
  cover property ($rose(ADDR_MODE_O));
endmodule : fsr_cmd_chk

bind fsr_cmd fsr_cmd_chk u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .HW_RESET_I(HW_RESET_I),
  .CS_N_I(CS_N_I), .IO_OE_O(IO_OE_O), .MEM_REQ_O(MEM_REQ_O), .STATUS_O(STATUS_O),
  .EXT_ADDR_O(EXT_ADDR_O), .ADDR_MODE_O(ADDR_MODE_O), .BUSY_O(BUSY_O), .WEL_O(WEL_O));

// ### fsr_host.sv
// Host controller model driving the serial flash link
`timescale 1ns/1ps
module fsr_host (
  // Clock
  input  wire logic        clk_i,
  // Link lanes as seen on the wire
  input  wire logic [3:0]  io_i,
  output logic             cs_n_o,
  output logic             sclk_o,
  output logic      [3:0]  io_o,
  // Read result
  output logic             done_o,
  output logic      [63:0] rdata_o
);
  // ========================================================================
  // Idle levels: clock low, lanes toggling so nothing passes as data
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h5;
    done_o = 1'b0;
    rdata_o = 64'h0;
  end

  // One framed transfer, MSB first, lanes held through each rising edge
  task automatic frame(input int lanes, input int nin, input logic [63:0] din, input int nrd);
    logic [63:0] d;
    d = 64'h0;
    cs_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < nin + nrd; i++) begin
      io_o <= (i >= nin) ? ~io_o : (lanes == 4) ? din[63-4*i -: 4] : {~io_o[3:1], din[63-i]};
      repeat (2) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      if (i >= nin) d = {d[62:0], io_i[1]};
      sclk_o <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b1;
    io_o <= ~io_o;
    rdata_o <= d;
    done_o <= (nrd > 0);
    @(posedge clk_i);
    done_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : frame
endmodule : fsr_host

// ### fsr_map.svh
// Opcodes, status field layout, reset values and timing counts of the flash command front end
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ==========================================================================
// Opcodes
`define FSR_OP_WREN      8'h06
`define FSR_OP_WRDI      8'h04
`define FSR_OP_VWREN     8'h50
`define FSR_OP_WRSR1     8'h01
`define FSR_OP_WRSR2     8'h31
`define FSR_OP_WRSR3     8'h11
`define FSR_OP_RDSR1     8'h05
`define FSR_OP_RDSR2     8'h35
`define FSR_OP_RDSR3     8'h15
`define FSR_OP_RDEXT     8'hC8
`define FSR_OP_WREXT     8'hC5
`define FSR_OP_EN32      8'hB7
`define FSR_OP_EX32      8'hE9
`define FSR_OP_READ      8'h03
`define FSR_OP_READ32    8'h13
`define FSR_OP_FREAD     8'h0B
`define FSR_OP_SETPARAM  8'hC0

// ==========================================================================
// Status field positions and writable masks
`define FSR_SR1_BUSY_BIT 0
`define FSR_SR1_WEL_BIT  1
`define FSR_SR1_WR_MASK  8'hFC
`define FSR_SR2_WR_MASK  8'h7B
`define FSR_SR2_QE_MASK  8'h02
`define FSR_SR2_SRL_MASK 8'h01
`define FSR_SR2_LB_MASK  8'h38
`define FSR_SR3_WR_MASK  8'hE6
`define FSR_SR3_ADP_BIT  1
`define FSR_SR3_ADS_BIT  0
`define FSR_PARAM_LSB    4
`define FSR_PARAM_MSB    5

// ==========================================================================
// Reset values and idle output byte
`define FSR_SR_RESET     8'h00
`define FSR_EXT_RESET    8'h00
`define FSR_PARAM_RESET  2'h0
`define FSR_IDLE_BYTE    8'hFF

// ==========================================================================
// Timing
`define FSR_CLK_MHZ      250
`define FSR_TW_NS        10000
`define FSR_TW_CYC       ((`FSR_TW_NS * `FSR_CLK_MHZ) / 1000)
`define FSR_SPI_DUMMY    4'h8

`endif

// ### fsr_pkg.sv
// Types shared by the flash command front end
package fsr_pkg;

  // ========================================================================
  // Engine states and output sources
  typedef enum logic [2:0] {
    FSR_ST_CMD, FSR_ST_ADDR, FSR_ST_DUMMY, FSR_ST_DIN, FSR_ST_OUT, FSR_ST_IGNORE
  } fsr_state_e;

  typedef enum logic [1:0] {FSR_SRC_STATUS, FSR_SRC_EXT, FSR_SRC_MEM} fsr_src_e;

  // ========================================================================
  // Status register bundle
  typedef struct packed {
    logic [7:0] sr3;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } fsr_status_s;

endpackage : fsr_pkg
